// ### hdl/asc_pkg.sv
package asc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int CODE_W = 10;
	localparam int PMUX_W = 8;
	localparam int NMUX_W = 3;
	// Register offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_MUX    = 4'h4;
	localparam logic [3:0] OFS_CODE   = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;
	// Control register bit positions
	localparam int B_NEG_GND  = 0;
	localparam int B_HOLD     = 1;
	localparam int B_PASS     = 2;
	localparam int B_LATCH_N  = 3;
	localparam int B_PROBE    = 4;
	localparam int B_SPEEDUP  = 5;
	localparam int B_VCC_REF  = 6;
	localparam int B_AMP_PWR  = 7;
	localparam int B_ADC_PWR  = 8;
	localparam int B_BG_REF   = 9;
	localparam int B_GAIN_CLK = 10;
	localparam int B_GAIN_PATH = 11;
	localparam int B_BG_NEG   = 12;
	localparam int B_BYPASS   = 13;
	localparam int B_G10      = 14;
	localparam int B_G20      = 15;
	localparam int CTRL_W     = 16;
	// Mux register field positions
	localparam int F_PMUX_LSB = 0;
	localparam int F_NMUX_LSB = 8;
	// Idle values and synchronizer depth
	localparam logic [15:0] CTRL_IDLE = 16'h200e;
	localparam logic [7:0]  PMUX_IDLE = 8'h01;
	localparam logic [2:0]  NMUX_IDLE = 3'h0;
	localparam logic [9:0]  CODE_IDLE = 10'h200;
	localparam int SYNC_STAGES = 3;
endpackage

// ### hdl/asc_sync.sv
`timescale 1ns/1ps
module asc_sync (
	input  wire logic clk_in,
	input  wire logic resetn_in,
	input  wire logic async_in,
	output logic      level_out
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic       level_q;
	logic       level_d;

	always_comb begin
		stage_d = {stage_q[1:0], async_in};
		level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level_out = level_q;
endmodule

// ### hdl/asc_top.sv
`timescale 1ns/1ps
module asc_top (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	input  wire logic        comparator_in,
	output logic [31:0]      rdata_out,
	output logic             negative_ground_out,
	output logic             sample_hold_out,
	output logic             gain_pass_gate_out,
	output logic             latch_reset_n_out,
	output logic             switchcap_probe_out,
	output logic             gain_speedup_out,
	output logic             supply_reference_select_out,
	output logic             amplifier_power_out,
	output logic             converter_power_out,
	output logic             bandgap_as_reference_out,
	output logic             gain_clock_out,
	output logic             gain_path_out,
	output logic             bandgap_negative_out,
	output logic             bypass_path_out,
	output logic             gain10_out,
	output logic             gain20_out,
	output logic [7:0]       positive_input_select_out,
	output logic [2:0]       negative_input_select_out,
	output logic [9:0]       trial_code_out,
	output logic             decision_out
);
	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic [7:0]  pmux_q;
	logic [7:0]  pmux_d;
	logic [2:0]  nmux_q;
	logic [2:0]  nmux_d;
	logic [9:0]  code_q;
	logic [9:0]  code_d;
	logic        decision_q;
	logic        decision_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        comp_sync;

	asc_sync u_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.async_in  (comparator_in),
		.level_out (comp_sync)
	);

	// Control vector loading
	always_comb begin
		ctrl_d = ctrl_q;
		pmux_d = pmux_q;
		nmux_d = nmux_q;
		code_d = code_q;
		if (wr_in) begin
			if (addr_in == asc_pkg::OFS_CTRL) begin
				ctrl_d = wdata_in[15:0];
			end else if (addr_in == asc_pkg::OFS_MUX) begin
				pmux_d = wdata_in[asc_pkg::F_PMUX_LSB +: 8];
				nmux_d = wdata_in[asc_pkg::F_NMUX_LSB +: 3];
			end else if (addr_in == asc_pkg::OFS_CODE) begin
				code_d = wdata_in[9:0];
			end
		end
	end

	// Comparator decision latch
	always_comb begin
		decision_d = decision_q;
		if (!ctrl_q[asc_pkg::B_ADC_PWR]) begin
			decision_d = 1'b0;
		end else if (!ctrl_q[asc_pkg::B_LATCH_N]) begin
			decision_d = 1'b0;
		end else if (ctrl_q[asc_pkg::B_HOLD]) begin
			decision_d = comp_sync;
		end
	end

	// Read path, data valid the cycle after the strobe
	always_comb begin
		rdata_d = 32'h0;
		if (rd_in) begin
			if (addr_in == asc_pkg::OFS_CTRL) begin
				rdata_d = {16'h0, ctrl_q};
			end else if (addr_in == asc_pkg::OFS_MUX) begin
				rdata_d = {21'h0, nmux_q, pmux_q};
			end else if (addr_in == asc_pkg::OFS_CODE) begin
				rdata_d = {22'h0, code_q};
			end else if (addr_in == asc_pkg::OFS_STATUS) begin
				rdata_d = {31'h0, decision_q};
			end
		end
	end

	// Control vector registers
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_q <= asc_pkg::CTRL_IDLE;
			pmux_q <= asc_pkg::PMUX_IDLE;
			nmux_q <= asc_pkg::NMUX_IDLE;
			code_q <= asc_pkg::CODE_IDLE;
		end else begin
			ctrl_q <= ctrl_d;
			pmux_q <= pmux_d;
			nmux_q <= nmux_d;
			code_q <= code_d;
		end
	end

	// Decision register
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			decision_q <= 1'h0;
		end else begin
			decision_q <= decision_d;
		end
	end

	// Read data register
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_out                   = rdata_q;
	assign negative_ground_out         = ctrl_q[asc_pkg::B_NEG_GND];
	assign sample_hold_out             = ctrl_q[asc_pkg::B_HOLD];
	assign gain_pass_gate_out          = ctrl_q[asc_pkg::B_PASS];
	assign latch_reset_n_out           = ctrl_q[asc_pkg::B_LATCH_N];
	assign switchcap_probe_out         = ctrl_q[asc_pkg::B_PROBE];
	assign gain_speedup_out            = ctrl_q[asc_pkg::B_SPEEDUP];
	assign supply_reference_select_out = ctrl_q[asc_pkg::B_VCC_REF];
	assign amplifier_power_out         = ctrl_q[asc_pkg::B_AMP_PWR];
	assign converter_power_out         = ctrl_q[asc_pkg::B_ADC_PWR];
	assign bandgap_as_reference_out    = ctrl_q[asc_pkg::B_BG_REF];
	assign gain_clock_out              = ctrl_q[asc_pkg::B_GAIN_CLK];
	assign gain_path_out               = ctrl_q[asc_pkg::B_GAIN_PATH];
	assign bandgap_negative_out        = ctrl_q[asc_pkg::B_BG_NEG];
	assign bypass_path_out             = ctrl_q[asc_pkg::B_BYPASS];
	assign gain10_out                  = ctrl_q[asc_pkg::B_G10];
	assign gain20_out                  = ctrl_q[asc_pkg::B_G20];
	assign positive_input_select_out   = pmux_q;
	assign negative_input_select_out   = nmux_q;
	assign trial_code_out              = code_q;
	assign decision_out                = decision_q;
endmodule

// ### test/asc_chk.sv
`timescale 1ns/1ps
module asc_chk (
	input wire logic        clk_in,
	input wire logic        resetn_in,
	input wire logic [3:0]  addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        negative_ground_out,
	input wire logic        sample_hold_out,
	input wire logic        latch_reset_n_out,
	input wire logic        converter_power_out,
	input wire logic [2:0]  negative_input_select_out,
	input wire logic [9:0]  trial_code_out,
	input wire logic        decision_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	wire logic wc = wr_in && addr_in == asc_pkg::OFS_CTRL;
	wire logic wm = wr_in && addr_in == asc_pkg::OFS_MUX;
	wire logic wk = wr_in && addr_in == asc_pkg::OFS_CODE;
	a_gnd_write:
		assert property (wc |=> negative_ground_out == $past(wdata_in[0])) else $error("gnd");
	a_hold_write:
		assert property (wc |=> sample_hold_out == $past(wdata_in[1])) else $error("hold");
	a_latch_write:
		assert property (wc |=> latch_reset_n_out == $past(wdata_in[3])) else $error("latch");
	a_power_write:
		assert property (wc |=> converter_power_out == $past(wdata_in[8])) else $error("pwr");
	a_nsel_write:
		assert property (wm |=> negative_input_select_out == $past(wdata_in[10:8]))
			else $error("nsel");
	a_code_write:
		assert property (wk |=> trial_code_out == $past(wdata_in[9:0])) else $error("code");
	a_decision_clear:
		assert property (!latch_reset_n_out |=> !decision_out) else $error("clear");
	a_power_clear:
		assert property (!converter_power_out |=> !decision_out) else $error("power clear");
	a_reset_idle:
		assert property ($rose(resetn_in) |-> sample_hold_out && latch_reset_n_out
			&& !converter_power_out && trial_code_out == 10'h200) else $error("idle");
endmodule

// ### test/asc_cmp_model.sv
`timescale 1ns/1ps
module asc_cmp_model (
	input  wire logic [9:0] code_in,
	input  wire logic [9:0] level_in,
	output logic            comp_out
);
	// Decision is high once the trial code passes the held level
	assign comp_out = code_in > level_in;
endmodule

// ### test/test_adc_scan_test_controls.sv
`timescale 1ns/1ps
module test_adc_scan_test_controls;
	logic clk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0, rdata_out;
	logic [9:0] level = 10'h0, code, trial_code_out;
	logic [7:0] positive_input_select_out;
	logic [2:0] negative_input_select_out;
	logic [15:0] d;
	logic comparator_in, decision_out, negative_ground_out, sample_hold_out, gain_pass_gate_out;
	logic latch_reset_n_out, switchcap_probe_out, gain_speedup_out, supply_reference_select_out;
	logic amplifier_power_out, converter_power_out, bandgap_as_reference_out, gain_clock_out;
	logic gain_path_out, bandgap_negative_out, bypass_path_out, gain10_out, gain20_out;
	wire logic [15:0] ctl = {gain20_out, gain10_out, bypass_path_out, bandgap_negative_out,
		gain_path_out, gain_clock_out, bandgap_as_reference_out, converter_power_out,
		amplifier_power_out, supply_reference_select_out, gain_speedup_out, switchcap_probe_out,
		latch_reset_n_out, gain_pass_gate_out, sample_hold_out, negative_ground_out};
	int errors = 0, cmp_count = 0;
	asc_top dut_u (.*);
	asc_cmp_model cm_u (.code_in(trial_code_out), .level_in(level), .comp_out(comparator_in));
	initial forever #20 clk_in = ~clk_in;
	// Keeps one negative source, gain stages and speed-up off
	function automatic logic [15:0] legal(logic [15:0] v);
		return v & ~16'hc8a0 & ~(16'(v[0]) << 12);
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] v);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= v;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task automatic rdc(string n, logic [3:0] a, logic [31:0] e);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(n, e, rdata_out);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		d = 16'($urandom(32'hcbf2));
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		#1;
		chk("ctl", asc_pkg::CTRL_IDLE, ctl);
		chk("pmux", asc_pkg::PMUX_IDLE, positive_input_select_out);
		chk("idle", 14'h0200, {negative_input_select_out, decision_out, trial_code_out});
		repeat (8) begin
			d = legal(16'($urandom));
			wr(asc_pkg::OFS_CTRL, {16'h0, d});
			chk("ctl", d, ctl);
			rdc("rd_ctl", asc_pkg::OFS_CTRL, {16'h0, d});
			wr(asc_pkg::OFS_MUX, {21'h0, d[10:0]});
			chk("mux", d[10:0], {negative_input_select_out, positive_input_select_out});
		end
		wr(4'h2, 32'hffff_ffff);
		rdc("unmapped", 4'h2, 32'h0);
		chk("ctl", d, ctl);
		wr(asc_pkg::OFS_CTRL, 32'h200e);
		level = 10'h100 + 10'($urandom_range(0, 255));
		for (int i = 0; i < 2; i++) begin
			code = level - 10'h1 + 10'(2 * i);
			wr(asc_pkg::OFS_CODE, {22'h0, asc_pkg::CODE_IDLE});
			wr(asc_pkg::OFS_CTRL, 32'h210c);
			wr(asc_pkg::OFS_CTRL, 32'h210e);
			wr(asc_pkg::OFS_CODE, {22'h0, code});
			chk("code", code, trial_code_out);
			wr(asc_pkg::OFS_CTRL, 32'h2106);
			wr(asc_pkg::OFS_CTRL, 32'h210e);
			repeat (6) @(posedge clk_in);
			rdc("comp", asc_pkg::OFS_STATUS, {31'h0, code > level});
			chk("decision", code > level, decision_out);
		end
		@(posedge clk_in);
		resetn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		#1;
		chk("ctl_rst", asc_pkg::CTRL_IDLE, ctl);
		chk("pmux_rst", asc_pkg::PMUX_IDLE, positive_input_select_out);
		chk("idle_rst", 14'h0200, {negative_input_select_out, decision_out, trial_code_out});
		give_verdict();
	end
endmodule
bind asc_top asc_chk chk_u (.clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
	.negative_ground_out, .sample_hold_out, .latch_reset_n_out, .converter_power_out,
	.negative_input_select_out, .trial_code_out, .decision_out);
